/* File: hw/angle_readout_pkg.sv */
`default_nettype none
package angle_readout_pkg;
  // Core clock rate and the timing figures converted from it.
  localparam int CORE_CLK_MHZ = 50;
  localparam real ANGLE_UPDATE_PERIOD_US = 1.0;
  localparam int ANGLE_UPDATE_CYCLES = int'(ANGLE_UPDATE_PERIOD_US * CORE_CLK_MHZ);
  localparam real ANGLE_PATH_LATENCY_US = 10.0;
  localparam int LATENCY_UPDATES = int'(ANGLE_PATH_LATENCY_US / ANGLE_UPDATE_PERIOD_US);
  localparam int LP_ANGLE_PERIOD_US = 32;
  localparam int LP_ANGLE_CYCLES = LP_ANGLE_PERIOD_US * CORE_CLK_MHZ;
  localparam int FIELD_PERIOD_US = 128;
  localparam int FIELD_CYCLES = FIELD_PERIOD_US * CORE_CLK_MHZ;
  localparam int SPI_VALID_US = 300;
  localparam int SPI_VALID_CYCLES = SPI_VALID_US * CORE_CLK_MHZ;

  // Widths of the angle, field and serial words.
  localparam int FINE_W = 15;
  localparam int COARSE_W = 12;
  localparam int WORD_W = 16;
  localparam int FIELD_W = 12;
  localparam int TURNS_W = 8;
  localparam int ADDR_W = 8;

  // Serial register map and command layout.
  localparam logic [7:0] ADDR_ANGLE_FLAGS = 8'h20;
  localparam logic [7:0] ADDR_FINE_ANGLE = 8'h32;
  localparam int CMD_READ_BIT = 15;

  // Field positions of the flagged angle word.
  localparam int ERROR_BIT = 14;
  localparam int UNDERVOLT_BIT = 13;
  localparam int PARITY_BIT = 12;

  // Reset values and the diagnostic comparison window.
  localparam logic [14:0] ANGLE_RESET = 15'h0000;
  localparam logic [11:0] FIELD_RESET = 12'h000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] TURNS_RESET = 8'h00;
  localparam logic [14:0] DIAG_TOLERANCE = 15'h0100;

  // Which register the next response frame carries.
  typedef enum logic [1:0] {SEL_NONE, SEL_FLAGS, SEL_FINE} resp_sel_t;

  // Parity bit that makes the whole 16-bit word hold an odd count of ones.
  function automatic logic odd_parity(input logic [14:0] v);
    return ~(^v);
  endfunction : odd_parity

  // Shortest circular distance between two fine angles.
  function automatic logic [14:0] angle_distance(input logic [14:0] a, input logic [14:0] b);
    logic [14:0] d;
    d = a - b;
    if (d[14]) begin
      d = 15'(~d + 15'h0001);
    end
    return d;
  endfunction : angle_distance
endpackage : angle_readout_pkg
`default_nettype wire

/* File: hw/serial_frame_port.sv */
`timescale 1ns/1ns
`default_nettype none
module serial_frame_port (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic port_enable,
  input wire logic [15:0] tx_word,
  output logic spi_miso,
  output logic spi_miso_oe,
  output logic frame_start,
  output logic rx_valid,
  output logic [15:0] rx_word
);
  logic sclk_s1_q, sclk_s2_q, sclk_s3_q, cs_s1_q, cs_s2_q, mosi_s1_q, mosi_s2_q;
  logic [4:0] bit_cnt_q, bit_cnt_d;
  logic first_q, first_d, load_q, load_d;
  logic [15:0] shift_q, shift_d, rx_q, rx_d, rx_word_q, rx_word_d;
  logic miso_q, miso_d, oe_q, oe_d, start_q, start_d, valid_q, valid_d;
  logic active, rise, fall;

  // Two-stage synchronisers; the third sclk stage only feeds edge detection.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      mosi_s1_q <= 1'b0;
      mosi_s2_q <= 1'b0;
    end else begin
      sclk_s1_q <= spi_sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      cs_s1_q <= spi_cs_n;
      cs_s2_q <= cs_s1_q;
      mosi_s1_q <= spi_mosi;
      mosi_s2_q <= mosi_s1_q;
    end
  end

  assign active = ~cs_s2_q & port_enable;
  assign rise = sclk_s2_q & ~sclk_s3_q;
  assign fall = ~sclk_s2_q & sclk_s3_q;

  // Frame engine: sample on rising sclk, shift out on falling sclk, MSB first.
  always_comb begin
    bit_cnt_d = bit_cnt_q;
    first_d = first_q;
    load_d = load_q;
    shift_d = shift_q;
    rx_d = rx_q;
    rx_word_d = rx_word_q;
    start_d = 1'b0;
    valid_d = 1'b0;
    oe_d = active;
    miso_d = miso_q;
    if (!active) begin
      bit_cnt_d = 5'h00;
      first_d = 1'b1;
      load_d = 1'b0;
      shift_d = angle_readout_pkg::WORD_RESET;
      miso_d = 1'b0;
    end else begin
      if (rise) begin
        rx_d = {rx_q[14:0], mosi_s2_q};
        bit_cnt_d = bit_cnt_q + 5'h01;
        if (first_q) begin
          start_d = 1'b1;
          first_d = 1'b0;
          load_d = 1'b1;
        end
        if (bit_cnt_q == 5'h0F) begin
          valid_d = 1'b1;
          rx_word_d = {rx_q[14:0], mosi_s2_q};
          bit_cnt_d = 5'h00;
          first_d = 1'b1;
        end
      end
      if (fall) begin
        if (load_q) begin
          shift_d = {tx_word[14:0], 1'b0};
          load_d = 1'b0;
        end else begin
          shift_d = {shift_q[14:0], 1'b0};
        end
        miso_d = shift_d[15];
      end
    end
  end

  // State registers of the frame engine.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      bit_cnt_q <= 5'h00;
      first_q <= 1'b1;
      load_q <= 1'b0;
      shift_q <= angle_readout_pkg::WORD_RESET;
      rx_q <= angle_readout_pkg::WORD_RESET;
      rx_word_q <= angle_readout_pkg::WORD_RESET;
      miso_q <= 1'b0;
      oe_q <= 1'b0;
      start_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      first_q <= first_d;
      load_q <= load_d;
      shift_q <= shift_d;
      rx_q <= rx_d;
      rx_word_q <= rx_word_d;
      miso_q <= miso_d;
      oe_q <= oe_d;
      start_q <= start_d;
      valid_q <= valid_d;
    end
  end

  assign spi_miso = miso_q;
  assign spi_miso_oe = oe_q;
  assign frame_start = start_q;
  assign rx_valid = valid_q;
  assign rx_word = rx_word_q;
endmodule : serial_frame_port
`default_nettype wire

/* File: hw/angle_readout_registers.sv */
// Summary of operation
// - New angle sample every 1.0 us at output rate select 0, stretched by powers of two otherwise.
// - Encoder angle lags sample by 10 updates, 10 us at output rate select 0.
// - Register 0x20: zero, error, undervoltage, parity, angle.
// - Flagged word always carries three status bits.
// - Register 0x32: zero then 15-bit angle.
// - Read address alone picks 12 or 15 bits.
// - PWM angle uses the 12-bit value.
// - Encoder output uses 15-bit angle.
// - Serial port accepts frames after 300 us.
// - Stored zero offset applied to reported angle.
// - Main path plus low-power diagnostic path.
// - Undervoltage flag follows low supply.
// - Response latched at frame's first sclk edge.
// - Low-power angle 32 us, field 128 us.
`timescale 1ns/1ns
`default_nettype none
module angle_readout_registers #(
  parameter int SPI_READY_CYCLES = angle_readout_pkg::SPI_VALID_CYCLES,
  parameter int FIELD_UPDATE_CYCLES = angle_readout_pkg::FIELD_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic [14:0] main_angle_raw,
  input wire logic [14:0] lp_angle_raw,
  input wire logic [11:0] field_raw,
  input wire logic [14:0] zero_offset,
  input wire logic [1:0] output_rate_select,
  input wire logic supply_low,
  output logic [11:0] pwm_angle,
  output logic [14:0] incremental_angle,
  output logic [14:0] lp_angle,
  output logic [11:0] field_strength,
  output logic [7:0] turns_count,
  output logic general_error_flag,
  output logic undervoltage_flag,
  output logic spi_ready
);
  localparam int DLY_N = angle_readout_pkg::LATENCY_UPDATES - 1;

  logic [8:0] upd_cnt_q, upd_cnt_d, upd_period;
  logic upd_stb;
  logic [14:0] main_angle_q, main_angle_d, inc_q, inc_d;
  logic [14:0] dly_q [0:DLY_N-1];
  logic [14:0] dly_d [0:DLY_N-1];
  logic [11:0] pwm_q, pwm_d;
  logic [10:0] lp_cnt_q, lp_cnt_d;
  logic lp_stb;
  logic [11:0] lp_gap_q, lp_gap_d;
  logic lp_seen_q, lp_seen_d;
  logic [14:0] lp_q, lp_d, lp_new;
  logic [15:0] field_cnt_q, field_cnt_d;
  logic [11:0] field_q, field_d;
  logic [7:0] turns_q, turns_d;
  logic err_q, err_d;
  logic uv_s1_q, uv_s2_q, uv_q;
  logic [15:0] por_cnt_q, por_cnt_d;
  logic ready_q, ready_d;
  angle_readout_pkg::resp_sel_t sel_q, sel_d;
  logic [15:0] tx_q, tx_d;
  logic frame_start, rx_valid;
  logic [15:0] rx_word;

  // Serial frame engine; it stays silent until the port is ready.
  serial_frame_port u_port (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .port_enable(ready_q),
    .tx_word(tx_q),
    .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe),
    .frame_start(frame_start),
    .rx_valid(rx_valid),
    .rx_word(rx_word)
  );

  // The output rate select stretches the refresh period by powers of two.
  assign upd_period = 9'(angle_readout_pkg::ANGLE_UPDATE_CYCLES) << output_rate_select;
  assign upd_stb = (upd_cnt_q == upd_period - 9'h001);
  assign lp_stb = (lp_cnt_q == 11'(angle_readout_pkg::LP_ANGLE_CYCLES - 1));
  assign lp_new = lp_angle_raw - zero_offset;

  // Main path: sample, offset, PWM copy and the latency line to the encoder.
  always_comb begin
    upd_cnt_d = upd_stb ? 9'h000 : upd_cnt_q + 9'h001;
    main_angle_d = main_angle_q;
    pwm_d = pwm_q;
    inc_d = inc_q;
    dly_d = dly_q;
    if (upd_stb) begin
      main_angle_d = main_angle_raw - zero_offset;
      pwm_d = main_angle_d[14:3];
      dly_d[0] = main_angle_q;
      for (int i = 1; i < DLY_N; i++) begin
        dly_d[i] = dly_q[i-1];
      end
      inc_d = dly_q[DLY_N-1];
    end
  end

  // Registers of the main path.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      upd_cnt_q <= 9'h000;
      main_angle_q <= angle_readout_pkg::ANGLE_RESET;
      pwm_q <= angle_readout_pkg::FIELD_RESET;
      inc_q <= angle_readout_pkg::ANGLE_RESET;
      for (int i = 0; i < DLY_N; i++) begin
        dly_q[i] <= angle_readout_pkg::ANGLE_RESET;
      end
    end else begin
      upd_cnt_q <= upd_cnt_d;
      main_angle_q <= main_angle_d;
      pwm_q <= pwm_d;
      inc_q <= inc_d;
      dly_q <= dly_d;
    end
  end

  // Low-power path: slow angle, field strength, turns and diagnostics.
  always_comb begin
    lp_cnt_d = lp_stb ? 11'h000 : lp_cnt_q + 11'h001;
    field_cnt_d = field_cnt_q + 16'h0001;
    lp_d = lp_q;
    field_d = field_q;
    turns_d = turns_q;
    err_d = err_q;
    lp_gap_d = lp_stb ? 12'h000 : lp_gap_q + 12'h001;  // Strobe spacing, checked below.
    lp_seen_d = lp_seen_q | lp_stb;  // Set once a first full interval has begun.
    if (field_cnt_q >= 16'(FIELD_UPDATE_CYCLES - 1)) begin
      field_cnt_d = 16'h0000;
      field_d = field_raw;
    end
    if (lp_stb) begin
      lp_d = lp_new;
      if (lp_q[14:13] == 2'h3 && lp_new[14:13] == 2'h0) begin
        turns_d = turns_q + 8'h01;
      end else if (lp_q[14:13] == 2'h0 && lp_new[14:13] == 2'h3) begin
        turns_d = turns_q - 8'h01;
      end
      err_d = angle_readout_pkg::angle_distance(main_angle_raw - zero_offset, lp_new) >
              angle_readout_pkg::DIAG_TOLERANCE;
    end
  end

  // Registers of the low-power path and the undervoltage synchroniser.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      lp_cnt_q <= 11'h000;
      field_cnt_q <= 16'h0000;
      lp_q <= angle_readout_pkg::ANGLE_RESET;
      field_q <= angle_readout_pkg::FIELD_RESET;
      turns_q <= angle_readout_pkg::TURNS_RESET;
      err_q <= 1'b0;
      uv_s1_q <= 1'b0;
      uv_s2_q <= 1'b0;
      uv_q <= 1'b0;
      lp_gap_q <= 12'h000;
      lp_seen_q <= 1'b0;
    end else begin
      lp_cnt_q <= lp_cnt_d;
      field_cnt_q <= field_cnt_d;
      lp_q <= lp_d;
      field_q <= field_d;
      turns_q <= turns_d;
      err_q <= err_d;
      lp_gap_q <= lp_gap_d;
      lp_seen_q <= lp_seen_d;
      uv_s1_q <= supply_low;
      uv_s2_q <= uv_s1_q;
      uv_q <= uv_s2_q;
    end
  end

  // Power-on wait, command decode and response latch.
  always_comb begin
    por_cnt_d = por_cnt_q;
    ready_d = ready_q;
    sel_d = sel_q;
    tx_d = tx_q;
    if (!ready_q) begin
      if (por_cnt_q == 16'(SPI_READY_CYCLES - 1)) begin
        ready_d = 1'b1;
      end else begin
        por_cnt_d = por_cnt_q + 16'h0001;
      end
    end
    if (rx_valid) begin
      if (!rx_word[angle_readout_pkg::CMD_READ_BIT]) begin
        sel_d = angle_readout_pkg::SEL_NONE;
      end else begin
        case (rx_word[7:0])
          angle_readout_pkg::ADDR_ANGLE_FLAGS: sel_d = angle_readout_pkg::SEL_FLAGS;
          angle_readout_pkg::ADDR_FINE_ANGLE: sel_d = angle_readout_pkg::SEL_FINE;
          default: sel_d = angle_readout_pkg::SEL_NONE;
        endcase
      end
    end
    if (frame_start) begin
      case (sel_q)
        angle_readout_pkg::SEL_FLAGS: begin
          tx_d = {1'b0, err_q, uv_q, 1'b0, main_angle_q[14:3]};
          tx_d[angle_readout_pkg::PARITY_BIT] = angle_readout_pkg::odd_parity(
              {tx_d[15:13], tx_d[11:0]});
        end
        angle_readout_pkg::SEL_FINE: tx_d = {1'b0, main_angle_q};
        default: tx_d = angle_readout_pkg::WORD_RESET;
      endcase
    end
  end

  // Registers of the serial response side.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      por_cnt_q <= 16'h0000;
      ready_q <= 1'b0;
      sel_q <= angle_readout_pkg::SEL_NONE;
      tx_q <= angle_readout_pkg::WORD_RESET;
    end else begin
      por_cnt_q <= por_cnt_d;
      ready_q <= ready_d;
      sel_q <= sel_d;
      tx_q <= tx_d;
    end
  end

  assign pwm_angle = pwm_q;
  assign incremental_angle = inc_q;
  assign lp_angle = lp_q;
  assign field_strength = field_q;
  assign turns_count = turns_q;
  assign general_error_flag = err_q;
  assign undervoltage_flag = uv_q;
  assign spi_ready = ready_q;

  // Checks tying outputs to their causes.
  sequence s_flags_frame;
    frame_start && sel_q == angle_readout_pkg::SEL_FLAGS;
  endsequence
  sequence s_fine_frame;
    frame_start && sel_q == angle_readout_pkg::SEL_FINE;
  endsequence

  property p_refresh;
    @(posedge core_clk) disable iff (!reset_n || output_rate_select != 2'h0)
      upd_stb |-> ##1 !upd_stb ##[49:49] upd_stb;
  endproperty
  a_refresh: assert property (p_refresh) else $error("angle refresh period wrong");

  property p_latency;
    @(posedge core_clk) disable iff (!reset_n || output_rate_select != 2'h0)
      upd_stb |-> ##[501:501] (incremental_angle == $past(main_angle_q, 500));
  endproperty
  a_latency: assert property (p_latency) else $error("encoder angle latency wrong");

  property p_flags_word;
    @(posedge core_clk) disable iff (!reset_n)
      s_flags_frame |=> (tx_q[15] == 1'b0 && tx_q[11:0] == $past(main_angle_q[14:3])
        && tx_q[14] == $past(err_q) && tx_q[13] == $past(uv_q));
  endproperty
  a_flags_word: assert property (p_flags_word) else $error("flagged word wrong");

  property p_parity;
    @(posedge core_clk) disable iff (!reset_n)
      s_flags_frame |=> (^tx_q) == 1'b1;
  endproperty
  a_parity: assert property (p_parity) else $error("parity not odd");

  property p_fine_word;
    @(posedge core_clk) disable iff (!reset_n)
      s_fine_frame |=> tx_q == {1'b0, $past(main_angle_q)};
  endproperty
  a_fine_word: assert property (p_fine_word) else $error("fine word wrong");

  property p_pwm;
    @(posedge core_clk) disable iff (!reset_n)
      upd_stb |=> pwm_angle == main_angle_q[14:3];
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm angle not from 12 bits");

  property p_ready;
    @(posedge core_clk) disable iff (!reset_n)
      !spi_ready |-> ##1 (!spi_miso_oe && !frame_start);
  endproperty
  a_ready: assert property (p_ready) else $error("port active before ready");

  property p_uv;
    @(posedge core_clk) disable iff (!reset_n)
      supply_low [*4] |-> undervoltage_flag;
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage flag missing");

  property p_lp_period;
    @(posedge core_clk) disable iff (!reset_n)
      lp_stb && lp_seen_q |-> lp_gap_q == 12'(angle_readout_pkg::LP_ANGLE_CYCLES - 1);
  endproperty
  a_lp_period: assert property (p_lp_period) else $error("low-power period wrong");

  property p_diag;
    @(posedge core_clk) disable iff (!reset_n)
      lp_stb && angle_readout_pkg::angle_distance(main_angle_raw - zero_offset, lp_new) >
        angle_readout_pkg::DIAG_TOLERANCE |=> general_error_flag;
  endproperty
  a_diag: assert property (p_diag) else $error("path mismatch not flagged");
endmodule : angle_readout_registers
`default_nettype wire

/* File: testbench/spi_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module spi_host_model #(
  parameter int HALF_CYCLES = 4
) (
  input wire logic core_clk,
  input wire logic spi_miso,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi
);
  // The serial clock idles low and no device is selected between frames.
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // One mode 0 frame: the command goes out MSB first and the answer is sampled at each rise.
  // The extra gap before the first rise lets a slow host be modelled as well.
  // address picks resolution
  task automatic xfer(input logic [15:0] cmd, input int gap, output logic [15:0] resp);
    @(posedge core_clk);
    spi_cs_n <= 1'b0;
    spi_mosi <= cmd[15];
    repeat (HALF_CYCLES + gap) @(posedge core_clk);
    for (int i = 15; i >= 0; i--) begin
      spi_sclk <= 1'b1;
      resp[i] = spi_miso;
      repeat (HALF_CYCLES) @(posedge core_clk);
      spi_sclk <= 1'b0;
      if (i > 0) begin
        spi_mosi <= cmd[i - 1];
      end
      repeat (HALF_CYCLES) @(posedge core_clk);
    end
    spi_cs_n <= 1'b1;
    spi_mosi <= ~spi_mosi;  // A released line never keeps its last bit.
    repeat (HALF_CYCLES) @(posedge core_clk);
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

/* File: testbench/angle_readout_registers_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(name, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("ERROR %s expected %0h seen %0h", name, exp, got); \
    end \
  end

module angle_readout_registers_tb;
  localparam int READY_CYC = 20;
  localparam int FIELD_CYC = 64;
  logic core_clk;
  logic reset_n;
  logic spi_sclk;
  logic spi_cs_n;
  logic spi_mosi;
  logic spi_miso;
  logic spi_miso_oe;
  logic miso_line;
  logic miso_last = 1'b0;
  logic [14:0] main_raw;
  logic [14:0] lp_raw;
  logic [11:0] field_raw;
  logic [14:0] offset;
  logic supply_low;
  logic [11:0] pwm_angle;
  logic [14:0] inc_angle;
  logic [14:0] lp_angle;
  logic [11:0] field_strength;
  logic general_error_flag;
  logic undervoltage_flag;
  logic spi_ready;
  logic [7:0] turns_count;
  logic [7:0] turns_base;
  logic [1:0] ors;
  int n_errors;
  int cmp_count;
  int seed;
  logic [15:0] resp;
  logic [15:0] cmds [8];
  logic [14:0] ang;
  logic [14:0] old_ang;

  angle_readout_registers #(
    .SPI_READY_CYCLES(READY_CYC),
    .FIELD_UPDATE_CYCLES(FIELD_CYC)
  ) i_angle_readout_registers (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe),
    .main_angle_raw(main_raw),
    .lp_angle_raw(lp_raw),
    .field_raw(field_raw),
    .zero_offset(offset),
    .output_rate_select(ors),
    .supply_low(supply_low),
    .pwm_angle(pwm_angle),
    .incremental_angle(inc_angle),
    .lp_angle(lp_angle),
    .field_strength(field_strength),
    .turns_count(turns_count),
    .general_error_flag(general_error_flag),
    .undervoltage_flag(undervoltage_flag),
    .spi_ready(spi_ready)
  );

  spi_host_model i_spi_host_model (
    .core_clk(core_clk),
    .spi_miso(miso_line),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi)
  );

  // A 50 MHz core clock.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // An undriven data line shows the opposite of the last driven bit to the host.
  always @(posedge core_clk) begin
    if (spi_miso_oe === 1'b1) begin
      miso_last <= spi_miso;
    end
  end
  assign miso_line = (spi_miso_oe === 1'b1) ? spi_miso : ~miso_last;

  // Expected answer to a command, built from the live angle and flags.
  function automatic logic [15:0] exp_word(input logic [15:0] cmd, input logic [14:0] a,
                                           input logic ef, input logic uv);
    logic [14:0] body;
    body = {ef, uv, ~(^{ef, uv, a[14:3]}), a[14:3]};
    if (cmd[15] !== 1'b1) return 16'h0000;
    if (cmd[7:0] == 8'h32) return {1'b0, a};
    if (cmd[7:0] != 8'h20) return 16'h0000;
    return {1'b0, body};
  endfunction : exp_word

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  // Applies new front-end values at a clock edge; the field value is random each time.
  task automatic drive(input logic [14:0] m, input logic [14:0] l, input logic [14:0] o,
                       input logic s);
    @(posedge core_clk);
    main_raw <= m;
    lp_raw <= l;
    offset <= o;
    supply_low <= s;
    field_raw <= 12'($random(seed));
  endtask : drive

  // Lets n edges pass and then samples after their updates have landed.
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wait_cyc

  // Main sequence: reset, start-up, register reads, diagnostics and path timing.
  initial begin
    seed = 95;
    n_errors = 0;
    cmp_count = 0;
    reset_n = 1'b0;
    main_raw = 15'h0000;
    lp_raw = 15'h0000;
    field_raw = 12'h000;
    offset = 15'h0000;
    supply_low = 1'b0;
    ors = 2'h0;
    cmds = '{16'h8020, 16'h8032, 16'h0020, 16'h8033, 16'h8032, 16'h8032, 16'h80FF, 16'h8020};
    wait_cyc(16);
    `CHK("reset pwm", 12'h000, pwm_angle)
    `CHK("reset oe", 1'b0, spi_miso_oe)
    @(posedge core_clk);
    reset_n <= 1'b1;
    wait_cyc(READY_CYC - 2);
    `CHK("ready early", 1'b0, spi_ready)
    for (int k = 0; k < 8 && spi_ready !== 1'b1; k++) wait_cyc(1);
    `CHK("ready", 1'b1, spi_ready)
    if (spi_ready !== 1'b1) end_sim();
    // Random angles and offsets, alternating supply states, read through every command kind.
    i_spi_host_model.xfer(cmds[0], 0, resp);
    for (int k = 1; k < 13; k++) begin
      ang = 15'($random(seed));
      drive(ang, ang, 15'($random(seed)), k[0]);
      wait_cyc(120);
      ang = main_raw - offset;
      `CHK("pwm", ang[14:3], pwm_angle)
      `CHK("uv flag", supply_low, undervoltage_flag)
      i_spi_host_model.xfer(cmds[k % 8], (k % 3) * 12, resp);
      `CHK("word", exp_word(cmds[(k - 1) % 8], ang, 1'b0, supply_low), resp)
    end
    ang = 15'($random(seed));
    drive(ang, ang + 15'h0101, 15'h0000, 1'b0);
    wait_cyc(1700);
    `CHK("error flag", 1'b1, general_error_flag)
    `CHK("lp angle", 15'(ang + 15'h0101), lp_angle)
    `CHK("field", field_raw, field_strength)
    i_spi_host_model.xfer(16'h8020, 0, resp);
    i_spi_host_model.xfer(16'h8020, 0, resp);
    `CHK("word ef", exp_word(16'h8020, ang, 1'b1, 1'b0), resp)
    drive(ang, ang - 15'h0100, 15'h0000, 1'b0);
    wait_cyc(1700);
    `CHK("error edge", 1'b0, general_error_flag)
    old_ang = 15'($random(seed));
    drive(old_ang, old_ang, 15'h0123, 1'b0);
    wait_cyc(620);
    ang = 15'($random(seed));
    drive(ang, ang, 15'h0123, 1'b0);
    old_ang = old_ang - 15'h0123;
    ang = ang - 15'h0123;
    wait_cyc(55);
    `CHK("pwm refresh", ang[14:3], pwm_angle)
    wait_cyc(390);
    `CHK("enc old", old_ang, inc_angle)
    wait_cyc(175);
    `CHK("enc new", ang, inc_angle)
    drive(15'h7000, 15'h7000, 15'h0000, 1'b0);
    wait_cyc(1700);
    turns_base = turns_count;
    drive(15'h0800, 15'h0800, 15'h0000, 1'b0);
    wait_cyc(1700);
    `CHK("turns up", 8'(turns_base + 8'h01), turns_count)
    drive(15'h7000, 15'h7000, 15'h0000, 1'b0);
    wait_cyc(1700);
    `CHK("turns down", turns_base, turns_count)
    @(posedge core_clk);
    ors <= 2'h1;
    drive(15'h1000, 15'h1000, 15'h0000, 1'b0);
    for (int n = 0; n < 200 && pwm_angle !== 12'h200; n++) wait_cyc(1);
    drive(15'h2000, 15'h2000, 15'h0000, 1'b0);
    wait_cyc(98);
    `CHK("slow hold", 12'h200, pwm_angle)
    wait_cyc(1);
    `CHK("slow refresh", 12'h400, pwm_angle)
    end_sim();
  end
endmodule : angle_readout_registers_tb
`default_nettype wire
